// ===== logic/esrd_top.sv
// external stop request decoder: priority decode, stop sequencer, two-channel pulse cancel
// assumes a one-cycle ipo_tick from local logic and an Avalon-MM master on the same clock
// Behaviour
// - E without retraction brakes on the path as D, but loads no transition timer and never enters operating stop
// - misconfigured retraction delays braking at most two ticks
// - after E delay or retraction, brake current limit
// - A/B status high while A/B active or on fault or standstill command
// - C status high only while C active
// - D status high only while D active
// - E status nonzero only while E active
// - active-low requests decoded A, C, D, E priority
// - all requests high selects no stop
// - bit 6 enables stops, bit 4 enables retraction
// - status index 0 A/B, 1 C, 2 D, 3 E
// - pulse cancel over bus path and terminal path
// - two-channel pulse feedback, bus and terminal pair
// - optional internal pulse feedback, terminals unused
// - fault or standstill command cancels drive pulses
// - queue limit shutdowns during A, apply on release
// - C/D start loads timer, expiry enters operating stop
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module esrd_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [esrd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [esrd_pkg::DATA_W-1:0] avs_writedata,
  output logic [esrd_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // local events on this clock
  input wire logic ipo_tick,
  input wire logic drive_fault,
  input wire logic limit_violation,
  // stop request pins, active low, asynchronous
  input wire logic [esrd_pkg::NUM_REQ-1:0] stop_req_n,
  // pulse feedback pins, asynchronous
  input wire logic pulse_fb_bus,
  input wire logic [1:0] pulse_feedback_terminals,
  // stop status outputs
  output logic [esrd_pkg::NUM_REQ-1:0] stop_status,
  // stop actions
  output logic brake_current,
  output logic brake_path,
  output logic retract_active,
  output logic safe_operating_stop,
  output logic shutdown_apply,
  // two-channel pulse cancellation and its feedback
  output logic pulse_off_bus,
  output logic pulse_off_term,
  output logic fb_bus_status,
  output logic fb_term_status
);
  localparam int SYNC_W = esrd_pkg::NUM_REQ + 3; // requests, bus feedback, terminal pair
  localparam logic [SYNC_W-1:0] SYNC_RST = '1; // idle level: no request, feedback high

  // priority decode of the active-low request word
  function automatic esrd_pkg::esrd_req_e decode_req(input logic [esrd_pkg::NUM_REQ-1:0] req_n,
                                                      input logic en);
    esrd_pkg::esrd_req_e r;
    r = esrd_pkg::REQ_NONE;
    if (!en) begin
      r = esrd_pkg::REQ_NONE; // disabled: pins ignored
    end else if (!req_n[esrd_pkg::IDX_A]) begin
      r = esrd_pkg::REQ_A;
    end else if (!req_n[esrd_pkg::IDX_C]) begin
      r = esrd_pkg::REQ_C;
    end else if (!req_n[esrd_pkg::IDX_D]) begin
      r = esrd_pkg::REQ_D;
    end else if (!req_n[esrd_pkg::IDX_E]) begin
      r = esrd_pkg::REQ_E;
    end
    return r;
  endfunction

  logic [SYNC_W-1:0] sync_w; // synchronised pins
  logic [esrd_pkg::NUM_REQ-1:0] req_reg; // request word sampled on tick
  logic [esrd_pkg::DATA_W-1:0] ctrl_reg; // control word
  logic [esrd_pkg::TIMER_W-1:0] time_c_reg; // C to operating stop, ticks
  logic [esrd_pkg::TIMER_W-1:0] time_d_reg; // D to operating stop, ticks
  logic [esrd_pkg::TIMER_W-1:0] retract_reg; // retraction interval, ticks
  logic [esrd_pkg::TIMER_W-1:0] sos_cnt_reg; // transition timer
  logic [esrd_pkg::TIMER_W-1:0] e_cnt_reg; // E delay or retraction timer
  logic ack_reg; // bus answer cycle
  logic [esrd_pkg::DATA_W-1:0] rdata_reg; // read data
  esrd_pkg::esrd_state_e state_reg, state_next;
  esrd_pkg::esrd_req_e req_dec; // decoded request
  logic forced; // fault or commanded standstill
  logic queued_reg; // shutdown held back during A
  logic [esrd_pkg::DATA_W-1:0] status_word; // status read value
  logic bus_fire; // access completes this edge
  logic enter_cd; // C or D sequence starts this edge

  // pin synchroniser
  esrd_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({pulse_feedback_terminals, pulse_fb_bus, stop_req_n}),
    .sync_out(sync_w)
  );

  // request word taken once per tick
  always_ff @(posedge clk) begin
    if (srst) begin
      req_reg <= '1;
    end else if (ipo_tick) begin
      req_reg <= sync_w[esrd_pkg::NUM_REQ-1:0];
    end
  end

  assign req_dec = decode_req(req_reg, ctrl_reg[esrd_pkg::BIT_EN_EXT_STOP]);
  assign forced = drive_fault | ctrl_reg[esrd_pkg::BIT_STANDSTILL_CMD];

  // next sequencer state, re-evaluated each tick
  always_comb begin
    state_next = state_reg;
    if (forced) begin
      state_next = esrd_pkg::ST_PULSE;
    end else if (ipo_tick) begin
      unique case (req_dec)
        esrd_pkg::REQ_NONE: state_next = esrd_pkg::ST_IDLE;
        esrd_pkg::REQ_A: state_next = esrd_pkg::ST_PULSE;
        esrd_pkg::REQ_C: state_next = esrd_pkg::ST_CURRENT;
        esrd_pkg::REQ_D: state_next = esrd_pkg::ST_PATH;
        esrd_pkg::REQ_E: begin
          if (state_reg == esrd_pkg::ST_RETRACT || state_reg == esrd_pkg::ST_E_WAIT) begin
            // interval over: brake at current limit
            if (e_cnt_reg == esrd_pkg::TIMER_ZERO) begin
              state_next = esrd_pkg::ST_E_BRAKE;
            end
          end else if (state_reg == esrd_pkg::ST_E_BRAKE || state_reg == esrd_pkg::ST_E_PATH) begin
            state_next = state_reg;
          end else if (!ctrl_reg[esrd_pkg::BIT_EN_EXT_RETRACT]) begin
            state_next = esrd_pkg::ST_E_PATH;
          end else if (ctrl_reg[esrd_pkg::BIT_RETRACT_FAULT]) begin
            state_next = esrd_pkg::ST_E_WAIT;
          end else if (ctrl_reg[esrd_pkg::BIT_RETRACT_CFG]) begin
            state_next = esrd_pkg::ST_RETRACT;
          end else begin
            state_next = esrd_pkg::ST_E_PATH;
          end
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= esrd_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // E delay or retraction interval, loaded on entry, counted on ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      e_cnt_reg <= esrd_pkg::TIMER_ZERO;
    end else if (state_next == esrd_pkg::ST_E_WAIT && state_reg != esrd_pkg::ST_E_WAIT) begin
      e_cnt_reg <= esrd_pkg::ESR_FAULT_DELAY_IPO - esrd_pkg::TIMER_ONE;
    end else if (state_next == esrd_pkg::ST_RETRACT && state_reg != esrd_pkg::ST_RETRACT) begin
      e_cnt_reg <= retract_reg;
    end else if (ipo_tick && e_cnt_reg != esrd_pkg::TIMER_ZERO) begin
      e_cnt_reg <= e_cnt_reg - esrd_pkg::TIMER_ONE;
    end
  end

  assign enter_cd = (state_next == esrd_pkg::ST_CURRENT || state_next == esrd_pkg::ST_PATH)
                    && state_next != state_reg;

  // transition timer to operating stop
  always_ff @(posedge clk) begin
    if (srst) begin
      sos_cnt_reg <= esrd_pkg::TIMER_ZERO;
      safe_operating_stop <= 1'b0;
    end else if (enter_cd) begin
      sos_cnt_reg <= (state_next == esrd_pkg::ST_CURRENT) ? time_c_reg : time_d_reg;
      safe_operating_stop <= 1'b0;
    end else if (state_reg != esrd_pkg::ST_CURRENT && state_reg != esrd_pkg::ST_PATH) begin
      sos_cnt_reg <= esrd_pkg::TIMER_ZERO;
      safe_operating_stop <= 1'b0;
    end else if (ipo_tick) begin
      // count down, then hand over to standstill monitoring
      if (sos_cnt_reg == esrd_pkg::TIMER_ZERO) begin
        safe_operating_stop <= 1'b1;
      end else begin
        sos_cnt_reg <= sos_cnt_reg - esrd_pkg::TIMER_ONE;
      end
    end
  end

  // shutdown responses held back while pulses are externally cancelled
  always_ff @(posedge clk) begin
    if (srst) begin
      queued_reg <= 1'b0;
      shutdown_apply <= 1'b0;
    end else if (state_reg == esrd_pkg::ST_PULSE && state_next == esrd_pkg::ST_PULSE) begin
      queued_reg <= queued_reg | limit_violation;
      shutdown_apply <= 1'b0;
    end else begin
      // release or no hold: queued and fresh violations apply now
      queued_reg <= 1'b0;
      shutdown_apply <= queued_reg | limit_violation;
    end
  end

  // action and status outputs from the state
  always_ff @(posedge clk) begin
    if (srst) begin
      stop_status <= '0;
      brake_current <= 1'b0;
      brake_path <= 1'b0;
      retract_active <= 1'b0;
      pulse_off_bus <= 1'b0;
      pulse_off_term <= 1'b0;
    end else begin
      stop_status[esrd_pkg::IDX_A] <= state_reg == esrd_pkg::ST_PULSE;
      stop_status[esrd_pkg::IDX_C] <= state_reg == esrd_pkg::ST_CURRENT;
      stop_status[esrd_pkg::IDX_D] <= state_reg == esrd_pkg::ST_PATH;
      stop_status[esrd_pkg::IDX_E] <= state_reg == esrd_pkg::ST_E_PATH || state_reg == esrd_pkg::ST_RETRACT
                                      || state_reg == esrd_pkg::ST_E_WAIT || state_reg == esrd_pkg::ST_E_BRAKE;
      brake_current <= state_reg == esrd_pkg::ST_CURRENT || state_reg == esrd_pkg::ST_E_BRAKE;
      brake_path <= state_reg == esrd_pkg::ST_PATH || state_reg == esrd_pkg::ST_E_PATH;
      retract_active <= state_reg == esrd_pkg::ST_RETRACT;
      pulse_off_bus <= state_reg == esrd_pkg::ST_PULSE;
      pulse_off_term <= state_reg == esrd_pkg::ST_PULSE;
    end
  end

  // two-channel feedback: bus path, and terminal pair or internal loop
  always_ff @(posedge clk) begin
    if (srst) begin
      fb_bus_status <= 1'b0;
      fb_term_status <= 1'b0;
    end else begin
      fb_bus_status <= sync_w[esrd_pkg::NUM_REQ];
      if (ctrl_reg[esrd_pkg::BIT_INT_FEEDBACK]) begin
        fb_term_status <= pulse_off_term;
      end else begin
        fb_term_status <= &sync_w[SYNC_W-1:esrd_pkg::NUM_REQ+1];
      end
    end
  end

  // status word seen by software
  always_comb begin
    status_word = '0;
    status_word[esrd_pkg::NUM_REQ-1:0] = stop_status;
    status_word[esrd_pkg::STAT_SOS] = safe_operating_stop;
    status_word[esrd_pkg::STAT_QUEUED] = queued_reg;
    status_word[esrd_pkg::STAT_FB_BUS] = fb_bus_status;
    status_word[esrd_pkg::STAT_FB_TERM] = fb_term_status;
    status_word[esrd_pkg::STAT_PULSE_OFF] = pulse_off_bus;
  end

  // one wait cycle per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign bus_fire = (avs_read | avs_write) & ack_reg;
  assign avs_readdata = rdata_reg;

  // answer strobe and read data capture
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        unique case (avs_address)
          esrd_pkg::OFF_CTRL: rdata_reg <= ctrl_reg;
          esrd_pkg::OFF_TIME_C: rdata_reg <= {{(esrd_pkg::DATA_W-esrd_pkg::TIMER_W){1'b0}}, time_c_reg};
          esrd_pkg::OFF_TIME_D: rdata_reg <= {{(esrd_pkg::DATA_W-esrd_pkg::TIMER_W){1'b0}}, time_d_reg};
          esrd_pkg::OFF_RETRACT: rdata_reg <= {{(esrd_pkg::DATA_W-esrd_pkg::TIMER_W){1'b0}}, retract_reg};
          esrd_pkg::OFF_STATUS: rdata_reg <= status_word;
          default: rdata_reg <= '0; // unmapped reads zero
        endcase
      end
    end
  end

  // register writes take effect at the completing edge
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= esrd_pkg::CTRL_RST;
      time_c_reg <= esrd_pkg::TIME_C_RST;
      time_d_reg <= esrd_pkg::TIME_D_RST;
      retract_reg <= esrd_pkg::RETRACT_RST;
    end else if (bus_fire && avs_write) begin
      unique case (avs_address)
        esrd_pkg::OFF_CTRL: ctrl_reg <= avs_writedata;
        esrd_pkg::OFF_TIME_C: time_c_reg <= avs_writedata[esrd_pkg::TIMER_W-1:0];
        esrd_pkg::OFF_TIME_D: time_d_reg <= avs_writedata[esrd_pkg::TIMER_W-1:0];
        esrd_pkg::OFF_RETRACT: retract_reg <= avs_writedata[esrd_pkg::TIMER_W-1:0];
        default: ; // status and unmapped writes ignored
      endcase
    end
  end

  // checks
  sequence s_pulse_held_viol;
    state_reg == esrd_pkg::ST_PULSE && state_next == esrd_pkg::ST_PULSE && limit_violation;
  endsequence
  sequence s_pulse_release;
    state_reg == esrd_pkg::ST_PULSE && state_next != esrd_pkg::ST_PULSE;
  endsequence

  a_prio_pulse: assert property (@(posedge clk) disable iff (srst)
    ipo_tick && ctrl_reg[esrd_pkg::BIT_EN_EXT_STOP] && !req_reg[esrd_pkg::IDX_A] |=> ##1 stop_status == 4'h1)
    else $error("request A did not give pulse cancel only");
  a_prio_current: assert property (@(posedge clk) disable iff (srst)
    ipo_tick && !forced && ctrl_reg[esrd_pkg::BIT_EN_EXT_STOP] && req_reg[esrd_pkg::IDX_A]
    && !req_reg[esrd_pkg::IDX_C] |=> ##1 brake_current && !pulse_off_bus)
    else $error("request C did not brake at current limit");
  a_idle_none: assert property (@(posedge clk) disable iff (srst)
    ipo_tick && !forced && (&req_reg) |=> ##1 stop_status == 4'h0 && !brake_path && !brake_current)
    else $error("stop shown with no request");
  a_enable_gate: assert property (@(posedge clk) disable iff (srst)
    ipo_tick && !forced && !ctrl_reg[esrd_pkg::BIT_EN_EXT_STOP] |=> state_reg == esrd_pkg::ST_IDLE)
    else $error("stop taken while disabled");
  a_e_as_d: assert property (@(posedge clk) disable iff (srst)
    state_reg == esrd_pkg::ST_E_PATH |=> brake_path && stop_status[esrd_pkg::IDX_E] && !retract_active)
    else $error("E without retraction not handled as D");
  a_fault_delay: assert property (@(posedge clk) disable iff (srst)
    $rose(state_reg == esrd_pkg::ST_E_WAIT) |-> e_cnt_reg < esrd_pkg::ESR_FAULT_DELAY_IPO)
    else $error("misconfigured E delay too long");
  // delay used up on a tick with E still requested: braking must start now
  a_fault_brake: assert property (@(posedge clk) disable iff (srst)
    state_reg == esrd_pkg::ST_E_WAIT && ipo_tick && !forced && req_dec == esrd_pkg::REQ_E
    && e_cnt_reg == esrd_pkg::TIMER_ZERO |=> state_reg == esrd_pkg::ST_E_BRAKE)
    else $error("misconfigured E did not start braking in time");
  a_e_brake: assert property (@(posedge clk) disable iff (srst)
    state_reg == esrd_pkg::ST_E_BRAKE |=> brake_current && !brake_path)
    else $error("E did not brake at current limit");
  a_status_cd: assert property (@(posedge clk) disable iff (srst)
    ##1 stop_status[esrd_pkg::IDX_C] == $past(state_reg == esrd_pkg::ST_CURRENT)
    && stop_status[esrd_pkg::IDX_D] == $past(state_reg == esrd_pkg::ST_PATH))
    else $error("C or D status does not follow stop");
  a_two_channel: assert property (@(posedge clk) disable iff (srst)
    forced |=> ##1 pulse_off_bus && pulse_off_term && stop_status[esrd_pkg::IDX_A])
    else $error("fault did not cancel pulses on both channels");
  a_int_feedback: assert property (@(posedge clk) disable iff (srst)
    ctrl_reg[esrd_pkg::BIT_INT_FEEDBACK] |=> fb_term_status == $past(pulse_off_term))
    else $error("internal feedback does not follow pulse state");
  // a violation while pulses stay cancelled must be remembered
  a_queue_hold: assert property (@(posedge clk) disable iff (srst)
    s_pulse_held_viol |=> queued_reg)
    else $error("violation during held pulse cancel not queued");
  a_queue_apply: assert property (@(posedge clk) disable iff (srst)
    queued_reg ##0 s_pulse_release |=> shutdown_apply)
    else $error("queued shutdown not applied on release");
  a_sos_timer: assert property (@(posedge clk) disable iff (srst)
    enter_cd |=> !safe_operating_stop && sos_cnt_reg == $past(state_next == esrd_pkg::ST_CURRENT ? time_c_reg
    : time_d_reg))
    else $error("transition timer not loaded at C or D start");
  a_reset_clear: assert property (@(posedge clk)
    srst |=> stop_status == 4'h0 && sos_cnt_reg == esrd_pkg::TIMER_ZERO && e_cnt_reg == esrd_pkg::TIMER_ZERO)
    else $error("reset did not clear status and timers");
endmodule

// ===== logic/esrd_pkg.sv
// constants, register map and state encodings for the external stop request decoder
// assumes one 200 MHz clock domain and an interpolation tick from local logic
package esrd_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIMER_W = 16;
  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TIME_C = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TIME_D = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RETRACT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  // control word fields
  localparam int BIT_EN_EXT_RETRACT = 4;
  localparam int BIT_EN_EXT_STOP = 6;
  localparam int BIT_RETRACT_CFG = 8;
  localparam int BIT_RETRACT_FAULT = 9;
  localparam int BIT_INT_FEEDBACK = 10;
  localparam int BIT_STANDSTILL_CMD = 11;
  // request index per stop category, also status output index
  localparam int NUM_REQ = 4;
  localparam int IDX_A = 0;
  localparam int IDX_C = 1;
  localparam int IDX_D = 2;
  localparam int IDX_E = 3;
  // status word fields above the four stop bits
  localparam int STAT_SOS = 4;
  localparam int STAT_QUEUED = 5;
  localparam int STAT_FB_BUS = 6;
  localparam int STAT_FB_TERM = 7;
  localparam int STAT_PULSE_OFF = 8;
  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIME_C_RST = 16'h0010;
  localparam logic [TIMER_W-1:0] TIME_D_RST = 16'h0020;
  localparam logic [TIMER_W-1:0] RETRACT_RST = 16'h0008;
  // misconfigured retraction: braking starts this many ticks late at most
  localparam logic [TIMER_W-1:0] ESR_FAULT_DELAY_IPO = 16'h0002;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
  // decoded request after priority
  typedef enum logic [2:0] {REQ_NONE, REQ_A, REQ_C, REQ_D, REQ_E} esrd_req_e;
  // stop sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_PULSE, ST_CURRENT, ST_PATH, ST_E_PATH, ST_RETRACT, ST_E_WAIT, ST_E_BRAKE}
    esrd_state_e;
endpackage

// ===== logic/esrd_sync.sv
// two flip-flop synchroniser for a bundle of level inputs
// assumes each bit is an independent slow level; no bus coherence is given
`timescale 1ns/1ps
module esrd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage
  logic [WIDTH-1:0] sync_reg; // second stage
  // two stages, reset to the idle level
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule

// ===== verification/esrd_plc_model.sv
// partner model: safety controller that drives stop requests and mirrors drive feedback
// assumes the decoder's clock; requests change just after a rising edge
`timescale 1ns/1ps
module esrd_plc_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench commands, one bit per category, high means request
  input wire logic [esrd_pkg::NUM_REQ-1:0] stop_cmd,
  input wire logic term_wired,
  // what the decoder reports
  input wire logic [esrd_pkg::NUM_REQ-1:0] stop_status,
  input wire logic pulse_off_bus,
  input wire logic pulse_off_term,
  // request pins and feedback pins
  output logic [esrd_pkg::NUM_REQ-1:0] stop_req_n,
  output logic pulse_fb_bus,
  output logic [1:0] pulse_feedback_terminals,
  output logic [esrd_pkg::NUM_REQ-1:0] seen_status
);
  // request pins are active low, idle high
  always_ff @(posedge clk) begin
    if (srst) begin
      stop_req_n <= 4'hF;
    end else begin
      stop_req_n <= ~stop_cmd;
    end
  end
  // relay and terminal feedback follow the cut channels; unwired terminals sit low
  always_ff @(posedge clk) begin
    pulse_fb_bus <= pulse_off_bus;
    pulse_feedback_terminals <= term_wired ? {2{pulse_off_term}} : 2'b00;
  end
  // single-request test: controller reads back per-category status
  always_ff @(posedge clk) begin
    seen_status <= stop_status;
  end
endmodule

// ===== verification/esrd_top_tb.sv
// self-checking bench for the stop request decoder
// assumes the partner model on the request pins and an Avalon-MM master here
`timescale 1ns/1ps
module esrd_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [esrd_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [esrd_pkg::DATA_W-1:0] avs_writedata = '0;
  logic [esrd_pkg::DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic ipo_tick = 1'b0;
  logic drive_fault = 1'b0;
  logic limit_violation = 1'b0;
  logic [3:0] stop_req_n, stop_status, cmd = 4'h0, seen_status;
  logic pulse_fb_bus, brake_current, brake_path, retract_active, safe_operating_stop, shutdown_apply;
  logic pulse_off_bus, pulse_off_term, fb_bus_status, fb_term_status, term_wired = 1'b1;
  logic [1:0] pulse_feedback_terminals;
  logic [1:0] tick_cnt = 2'b00;
  logic [7:0] obs;
  int mismatches = 0;
  int cmp_count = 0;
  int sd_cnt = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // one-cycle interpolation tick every fourth cycle
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'b01;
    ipo_tick <= (tick_cnt == 2'b11);
  end
  // count applied shutdown pulses
  always @(posedge clk) begin
    if (shutdown_apply === 1'b1) sd_cnt++;
  end
  // observed action vector
  assign obs = {pulse_off_term, retract_active, brake_path, brake_current, stop_status};
  esrd_top esrd_top_i (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ipo_tick(ipo_tick), .drive_fault(drive_fault),
    .limit_violation(limit_violation), .stop_req_n(stop_req_n), .pulse_fb_bus(pulse_fb_bus),
    .pulse_feedback_terminals(pulse_feedback_terminals), .stop_status(stop_status),
    .brake_current(brake_current), .brake_path(brake_path), .retract_active(retract_active),
    .safe_operating_stop(safe_operating_stop), .shutdown_apply(shutdown_apply),
    .pulse_off_bus(pulse_off_bus), .pulse_off_term(pulse_off_term), .fb_bus_status(fb_bus_status),
    .fb_term_status(fb_term_status));
  esrd_plc_model esrd_plc_model_i (.clk(clk), .srst(srst), .stop_cmd(cmd), .term_wired(term_wired),
    .stop_status(stop_status), .pulse_off_bus(pulse_off_bus), .pulse_off_term(pulse_off_term),
    .stop_req_n(stop_req_n), .pulse_fb_bus(pulse_fb_bus),
    .pulse_feedback_terminals(pulse_feedback_terminals), .seen_status(seen_status));
  // verdict and stop
  task automatic end_of_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // compare a bus word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare a pin vector
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    q = '0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // request stands until the rising edge that sees waitrequest low
    while (!done && n < 50) begin
      @(posedge clk);
      done = (avs_waitrequest === 1'b0);
      if (done) begin
        q = avs_readdata;
      end
      n++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!done) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk_word(q, exp);
  endtask
  // let n edges pass, then look mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // expected actions per single request: A, C, D, E without retraction
  logic [7:0] exp_tab [4] = '{8'h81, 8'h12, 8'h24, 8'h28};
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    settle(1);
    chk_bits(obs, 8'h00);
    chk_rd(esrd_pkg::OFF_CTRL, 32'h0000_0000);
    chk_rd(esrd_pkg::OFF_TIME_C, 32'h0000_0010);
    chk_rd(esrd_pkg::OFF_TIME_D, 32'h0000_0020);
    chk_rd(esrd_pkg::OFF_RETRACT, 32'h0000_0008);
    chk_rd(8'h14, 32'h0000_0000);
    // requests ignored until stops enabled
    cmd = 4'b0001;
    settle(24);
    chk_bits(obs, 8'h00);
    wr(esrd_pkg::OFF_CTRL, 32'h0000_0040);
    for (int i = 0; i < 4; i++) begin
      cmd = 4'b0001 << i;
      settle(24);
      chk_bits(obs, exp_tab[i]);
      chk_bits({4'h0, seen_status}, {4'h0, exp_tab[i][3:0]});
    end
    cmd = 4'b1111;
    settle(24);
    chk_bits(obs, 8'h81);
    chk_bits({5'b0, pulse_off_bus, fb_bus_status, fb_term_status}, 8'h07);
    cmd = 4'b1110;
    settle(24);
    chk_bits(obs, 8'h12);
    cmd = 4'b0000;
    settle(24);
    chk_bits(obs, 8'h00);
    // misconfigured retraction brakes at current limit
    wr(esrd_pkg::OFF_CTRL, 32'h0000_0250);
    cmd = 4'b1000;
    settle(32);
    chk_bits(obs, 8'h18);
    cmd = 4'b0000;
    settle(24);
    // configured retraction, then current-limit braking
    wr(esrd_pkg::OFF_CTRL, 32'h0000_0150);
    cmd = 4'b1000;
    settle(20);
    chk_bits(obs, 8'h48);
    settle(48);
    chk_bits(obs, 8'h18);
    cmd = 4'b0000;
    settle(24);
    // short transition timer leads to operating stop
    wr(esrd_pkg::OFF_CTRL, 32'h0000_0040);
    wr(esrd_pkg::OFF_TIME_C, 32'h0000_0002);
    cmd = 4'b0010;
    settle(40);
    chk_rd(esrd_pkg::OFF_STATUS, 32'h0000_0012);
    // violation queued while pulses held off
    cmd = 4'b0001;
    settle(24);
    @(posedge clk);
    limit_violation <= 1'b1;
    @(posedge clk);
    limit_violation <= 1'b0;
    settle(8);
    chk_word(sd_cnt, 0);
    cmd = 4'b0000;
    settle(24);
    chk_word(sd_cnt, 1);
    // drive fault cuts pulses
    @(posedge clk);
    drive_fault <= 1'b1;
    settle(3);
    chk_bits(obs, 8'h81);
    @(posedge clk);
    drive_fault <= 1'b0;
    // internal feedback with unwired terminals
    term_wired = 1'b0;
    wr(esrd_pkg::OFF_CTRL, 32'h0000_0440);
    cmd = 4'b0001;
    settle(24);
    chk_bits({7'b0, fb_term_status}, 8'h01);
    cmd = 4'b0000;
    settle(24);
    end_of_test();
  end
endmodule
